// >>> core/pwmcab_pkg.sv
package pwmcab_pkg;

    // channel geometry
    localparam int NUM_CH = 8;
    localparam int NUM_PAIRS = NUM_CH / 2;
    localparam int APB_ADDR_W = 8;
    localparam int IDX_W = APB_ADDR_W - 2;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CHANNEL_ENABLE = 6'h00;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_POLARITY = 6'h01;
    localparam logic [IDX_W-1:0] IDX_SCALED_SELECT = 6'h02;
    localparam logic [IDX_W-1:0] IDX_CENTRE_ALIGN = 6'h04;
    localparam logic [IDX_W-1:0] IDX_MODULE_CONTROL = 6'h05;
    localparam logic [IDX_W-1:0] IDX_CLOCK_FAMILY = 6'h06;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h07;

    // module_control field positions
    localparam int CTL_JOIN_PAIR_ZERO_ONE = 4;
    localparam int CTL_JOIN_PAIR_TWO_THREE = 5;
    localparam int CTL_JOIN_PAIR_FOUR_FIVE = 6;
    localparam int CTL_JOIN_PAIR_SIX_SEVEN = 7;
    localparam int CTL_HALT_IN_WAIT = 3;
    localparam int CTL_HALT_IN_FREEZE = 2;
    localparam logic [7:0] CTL_RESERVED_MASK = 8'h03;

    // status field positions
    localparam int STS_WAIT = 0;
    localparam int STS_FREEZE = 1;
    localparam int STS_RUN = 2;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // clock source codes {family_b, scaled}
    localparam logic [1:0] SRC_A = 2'b00;
    localparam logic [1:0] SRC_SA = 2'b01;
    localparam logic [1:0] SRC_B = 2'b10;
    localparam logic [1:0] SRC_SB = 2'b11;

    // apb slave states, one-hot
    typedef enum logic [1:0] {
        PWMCAB_ST_IDLE = 2'b01,
        PWMCAB_ST_RESP = 2'b10
    } pwmcab_apb_state_t;

endpackage

// >>> core/pwmcab_src_sel.sv
`timescale 1ns/1ps
`default_nettype none

module pwmcab_src_sel #(
    parameter int NCH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [NCH-1:0] scaled_sel,
    input wire logic [NCH-1:0] family_sel,
    input wire logic [NCH/2-1:0] pair_join,
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic tick_sa,
    input wire logic tick_sb,
    output logic [NCH-1:0] chan_tick,
    output logic [2*NCH-1:0] chan_src
);

    typedef struct packed {
        logic [NCH-1:0] tick;
        logic [2*NCH-1:0] src;
    } pwmcab_sel_state_t;

    pwmcab_sel_state_t q;
    pwmcab_sel_state_t d;

    // family bit meaning flips for channels 2,3,6,7
    function automatic logic [1:0] src_code(input int ch, input logic fam, input logic scl);
        logic is_b;
        is_b = ((ch % 4) >= 2) ? ~fam : fam; // [RL9] [RL10]
        return {is_b, scl}; // [RL11] [RL12]
    endfunction

    always_comb begin
        int ctl_ch;
        logic [1:0] code;
        ctl_ch = 0;
        code = pwmcab_pkg::SRC_A;
        d = q;
        for (int i = 0; i < NCH; i++) begin
            // joined pair takes odd channel's selects
            ctl_ch = pair_join[i/2] ? (i | 1) : i; // [RL5]
            code = src_code(ctl_ch, family_sel[ctl_ch], scaled_sel[ctl_ch]);
            d.src[2*i +: 2] = code;
            case (code)
                pwmcab_pkg::SRC_A: d.tick[i] = run & tick_a;
                pwmcab_pkg::SRC_SA: d.tick[i] = run & tick_sa;
                pwmcab_pkg::SRC_B: d.tick[i] = run & tick_b; // [RL15]
                pwmcab_pkg::SRC_SB: d.tick[i] = run & tick_sb;
                default: d.tick[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign chan_tick = q.tick;
    assign chan_src = q.src;

endmodule

`default_nettype wire

// >>> core/pwmcab_ctrl.sv
// Summary of operation
// RL1: pair join bit clear keeps both channels as separate 8-bit channels.
// RL2: pair join bit set makes one 16-bit channel, even channel high byte.
// RL3: join bits sit at control bits 7,6,5,4 for pairs 6/7,4/5,2/3,0/1.
// RL4: joined pair drives its waveform on the odd channel's output pin.
// RL5: joined pair uses odd channel clock, polarity, enable and alignment.
// RL6: halt_in_wait at bit 3 stops prescaler clock during wait mode.
// RL7: halt_in_freeze at bit 2 stops prescaler clock during freeze mode.
// RL8: registers stay accessible when frozen; clock resumes on bit clear or exit.
// RL9: channels 0,1,4,5: family bit 0 picks A/SA, 1 picks B/SB.
// RL10: channels 2,3,6,7: family bit 0 picks B/SB, 1 picks A/SA.
// RL11: final source combines scaled select bit and family select bit.
// RL12: scaled select 0 picks unscaled clock, 1 picks scaled clock.
// RL13: bits of absent channels ignore writes and read as zero.
// RL14: family select readable and writable any time, glitch possible.
// RL15: gated prescaler clock holds counters; they resume from held values.
`timescale 1ns/1ps
`default_nettype none

module pwmcab_ctrl #(
    parameter logic [7:0] CHANNEL_MASK = 8'hff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwmcab_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mcu_wait,
    input wire logic mcu_freeze,
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic tick_sa,
    input wire logic tick_sb,
    input wire logic [pwmcab_pkg::NUM_CH-1:0] chan_wave,
    input wire logic [pwmcab_pkg::NUM_PAIRS-1:0] wave16,
    output logic [pwmcab_pkg::NUM_CH-1:0] chan_tick,
    output logic [2*pwmcab_pkg::NUM_CH-1:0] chan_src,
    output logic [pwmcab_pkg::NUM_PAIRS-1:0] pair_joined,
    output logic prescaler_run,
    output logic [pwmcab_pkg::NUM_CH-1:0] eff_enable,
    output logic [pwmcab_pkg::NUM_CH-1:0] eff_polarity,
    output logic [pwmcab_pkg::NUM_CH-1:0] eff_centre,
    output logic [pwmcab_pkg::NUM_CH-1:0] pwm_output_port
);

    localparam int NCH = pwmcab_pkg::NUM_CH;
    localparam int NP = pwmcab_pkg::NUM_PAIRS;

    typedef struct packed {
        pwmcab_pkg::pwmcab_apb_state_t st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] module_control;
        logic [7:0] scaled_select_register;
        logic [7:0] clock_family_select;
        logic [7:0] channel_enable;
        logic [7:0] output_polarity;
        logic [7:0] centre_align;
        logic prescaler_run;
        logic [NP-1:0] joined;
        logic [NCH-1:0] eff_enable;
        logic [NCH-1:0] eff_polarity;
        logic [NCH-1:0] eff_centre;
        logic [NCH-1:0] out_port;
    } pwmcab_ctrl_state_t;

    pwmcab_ctrl_state_t q;
    pwmcab_ctrl_state_t d;

    // pair exists only where both of its channels exist
    function automatic logic [NP-1:0] pair_mask(input logic [NCH-1:0] m);
        logic [NP-1:0] r;
        r = '0;
        for (int p = 0; p < NP; p++) begin
            r[p] = m[2*p] & m[2*p+1];
        end
        return r;
    endfunction

    // join bits of the control register, pair 0 first
    function automatic logic [NP-1:0] join_bits(input logic [7:0] ctl);
        return {ctl[pwmcab_pkg::CTL_JOIN_PAIR_SIX_SEVEN], ctl[pwmcab_pkg::CTL_JOIN_PAIR_FOUR_FIVE],
                ctl[pwmcab_pkg::CTL_JOIN_PAIR_TWO_THREE], ctl[pwmcab_pkg::CTL_JOIN_PAIR_ZERO_ONE]}; // [RL3]
    endfunction

    // odd channel control overrides even channel when joined
    function automatic logic [NCH-1:0] pair_ctl(input logic [NCH-1:0] v, input logic [NP-1:0] j);
        logic [NCH-1:0] r;
        r = v;
        for (int p = 0; p < NP; p++) begin
            if (j[p]) begin
                r[2*p] = v[2*p+1]; // [RL5]
            end
        end
        return r;
    endfunction

    localparam int IDX_W_L = pwmcab_pkg::IDX_W;
    localparam logic [3:0] CTL_HALT_MASK =
        4'((1 << pwmcab_pkg::CTL_HALT_IN_WAIT) | (1 << pwmcab_pkg::CTL_HALT_IN_FREEZE));
    logic [7:0] ctl_wmask;
    logic [IDX_W_L-1:0] acc_idx;

    assign ctl_wmask = {pair_mask(CHANNEL_MASK), CTL_HALT_MASK};
    assign acc_idx = paddr[pwmcab_pkg::APB_ADDR_W-1:2];

    always_comb begin
        logic commit;
        logic mapped;
        logic [7:0] rd;
        logic [7:0] wd;
        logic [NP-1:0] j;
        commit = 1'b0;
        mapped = 1'b0;
        rd = pwmcab_pkg::REG_RESET;
        wd = pwdata[7:0];
        j = '0;
        d = q;

        // register read mux and decode
        mapped = (paddr[1:0] == 2'b00);
        case (acc_idx)
            pwmcab_pkg::IDX_CHANNEL_ENABLE: rd = q.channel_enable;
            pwmcab_pkg::IDX_OUTPUT_POLARITY: rd = q.output_polarity;
            pwmcab_pkg::IDX_SCALED_SELECT: rd = q.scaled_select_register;
            pwmcab_pkg::IDX_CENTRE_ALIGN: rd = q.centre_align;
            pwmcab_pkg::IDX_MODULE_CONTROL: rd = q.module_control;
            pwmcab_pkg::IDX_CLOCK_FAMILY: rd = q.clock_family_select; // [RL14]
            pwmcab_pkg::IDX_STATUS: begin
                rd = pwmcab_pkg::REG_RESET;
                rd[pwmcab_pkg::STS_WAIT] = mcu_wait;
                rd[pwmcab_pkg::STS_FREEZE] = mcu_freeze;
                rd[pwmcab_pkg::STS_RUN] = q.prescaler_run;
            end
            default: mapped = 1'b0;
        endcase
        if (!mapped) begin
            rd = pwmcab_pkg::REG_RESET;
        end

        // apb slave, one wait state; registers reachable in freeze too
        case (q.st)
            pwmcab_pkg::PWMCAB_ST_IDLE: begin
                d.pready = 1'b0;
                d.pslverr = 1'b0;
                if (psel && penable) begin
                    d.st = pwmcab_pkg::PWMCAB_ST_RESP; // [RL8]
                    d.pready = 1'b1;
                    d.pslverr = ~mapped;
                    d.prdata = pwrite ? pwmcab_pkg::RDATA_RESET : {24'h000000, rd};
                end
            end
            pwmcab_pkg::PWMCAB_ST_RESP: begin
                commit = psel & penable;
                d.st = pwmcab_pkg::PWMCAB_ST_IDLE;
                d.pready = 1'b0;
                d.pslverr = 1'b0;
            end
            default: begin
                d.st = pwmcab_pkg::PWMCAB_ST_IDLE;
                d.pready = 1'b0;
                d.pslverr = 1'b0;
            end
        endcase

        // absent channel bits never store, so read back zero
        if (commit && pwrite && mapped) begin
            case (acc_idx)
                pwmcab_pkg::IDX_CHANNEL_ENABLE: d.channel_enable = wd & CHANNEL_MASK; // [RL13]
                pwmcab_pkg::IDX_OUTPUT_POLARITY: d.output_polarity = wd & CHANNEL_MASK;
                pwmcab_pkg::IDX_SCALED_SELECT: d.scaled_select_register = wd & CHANNEL_MASK;
                pwmcab_pkg::IDX_CENTRE_ALIGN: d.centre_align = wd & CHANNEL_MASK;
                pwmcab_pkg::IDX_MODULE_CONTROL: d.module_control = wd & ctl_wmask; // [RL13]
                pwmcab_pkg::IDX_CLOCK_FAMILY: d.clock_family_select = wd & CHANNEL_MASK; // [RL14]
                default: d.module_control = q.module_control;
            endcase
        end

        // prescaler input gating in wait and freeze
        d.prescaler_run = ~(mcu_wait & q.module_control[pwmcab_pkg::CTL_HALT_IN_WAIT]) // [RL6]
                          & ~(mcu_freeze & q.module_control[pwmcab_pkg::CTL_HALT_IN_FREEZE]); // [RL7] [RL8]

        // pair joining and effective per-channel controls
        j = join_bits(q.module_control);
        d.joined = j; // [RL1] [RL2]
        d.eff_enable = pair_ctl(q.channel_enable, j);
        d.eff_polarity = pair_ctl(q.output_polarity, j);
        d.eff_centre = pair_ctl(q.centre_align, j); // [RL5]

        // output pin routing
        for (int p = 0; p < NP; p++) begin
            if (j[p]) begin
                d.out_port[2*p+1] = wave16[p]; // [RL4]
                d.out_port[2*p] = 1'b0;
            end else begin
                d.out_port[2*p+1] = chan_wave[2*p+1]; // [RL1]
                d.out_port[2*p] = chan_wave[2*p];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.st <= pwmcab_pkg::PWMCAB_ST_IDLE;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.prdata <= pwmcab_pkg::RDATA_RESET;
            q.module_control <= pwmcab_pkg::REG_RESET;
            q.scaled_select_register <= pwmcab_pkg::REG_RESET;
            q.clock_family_select <= pwmcab_pkg::REG_RESET;
            q.channel_enable <= pwmcab_pkg::REG_RESET;
            q.output_polarity <= pwmcab_pkg::REG_RESET;
            q.centre_align <= pwmcab_pkg::REG_RESET;
            q.prescaler_run <= 1'b1;
            q.joined <= '0;
            q.eff_enable <= '0;
            q.eff_polarity <= '0;
            q.eff_centre <= '0;
            q.out_port <= '0;
        end else begin
            q <= d;
        end
    end

    // per-channel clock source selection, ticks stop while gated
    pwmcab_src_sel #(
        .NCH(NCH)
    ) u_src_sel (
        .pclk(pclk),
        .presetn(presetn),
        .run(q.prescaler_run), // [RL15]
        .scaled_sel(q.scaled_select_register),
        .family_sel(q.clock_family_select),
        .pair_join(q.joined),
        .tick_a(tick_a),
        .tick_b(tick_b),
        .tick_sa(tick_sa),
        .tick_sb(tick_sb),
        .chan_tick(chan_tick),
        .chan_src(chan_src)
    );

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign pair_joined = q.joined;
    assign prescaler_run = q.prescaler_run;
    assign eff_enable = q.eff_enable;
    assign eff_polarity = q.eff_polarity;
    assign eff_centre = q.eff_centre;
    assign pwm_output_port = q.out_port;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    halt_wait_a: assert property (mcu_wait && q.module_control[pwmcab_pkg::CTL_HALT_IN_WAIT]
        |=> !prescaler_run ##1 (chan_tick == '0)) else $error("prescaler not halted in wait"); // [RL6]

    halt_freeze_a: assert property (mcu_freeze && q.module_control[pwmcab_pkg::CTL_HALT_IN_FREEZE]
        |=> !prescaler_run) else $error("prescaler not halted in freeze"); // [RL7]

    clock_resume_a: assert property (!prescaler_run && !mcu_wait && !mcu_freeze
        |=> prescaler_run) else $error("prescaler clock did not resume"); // [RL8]

    gated_ticks_a: assert property (!prescaler_run && (tick_a || tick_b || tick_sa || tick_sb)
        |=> chan_tick == '0) else $error("channel tick while prescaler gated"); // [RL15]

    family_write_a: assert property (q.st == pwmcab_pkg::PWMCAB_ST_RESP && psel && penable && pwrite
        && acc_idx == pwmcab_pkg::IDX_CLOCK_FAMILY && paddr[1:0] == 2'b00
        |=> q.clock_family_select == ($past(pwdata[7:0]) & CHANNEL_MASK)) else $error("family write lost"); // [RL14]

    absent_bits_a: assert property ((q.clock_family_select & ~CHANNEL_MASK) == 8'h00
        && (q.module_control & ~ctl_wmask) == 8'h00) else $error("absent channel bit stored"); // [RL13]

    join_map_a: assert property (1'b1 |=> pair_joined == join_bits($past(q.module_control)))
        else $error("join bit mapping wrong"); // [RL3]

    for (genvar p = 0; p < NP; p++) begin : g_pair_chk
        joined_pin_a: assert property (q.module_control[pwmcab_pkg::CTL_JOIN_PAIR_ZERO_ONE + p]
            |=> pwm_output_port[2*p+1] == $past(wave16[p]) && !pwm_output_port[2*p])
            else $error("joined waveform not on odd pin"); // [RL4] [RL2]
        split_pin_a: assert property (!q.module_control[pwmcab_pkg::CTL_JOIN_PAIR_ZERO_ONE + p]
            |=> pwm_output_port[2*p +: 2] == $past(chan_wave[2*p +: 2]))
            else $error("split pair pins wrong"); // [RL1]
        odd_ctl_a: assert property (pair_joined[p]
            |-> eff_enable[2*p] == eff_enable[2*p+1] && eff_centre[2*p] == eff_centre[2*p+1]
            && eff_polarity[2*p] == eff_polarity[2*p+1]) else $error("even channel controls leak"); // [RL5]
        // source selector sees the join one edge later
        odd_src_a: assert property (pair_joined[p] // [RL5]
            |=> chan_src[4*p +: 2] == chan_src[4*p+2 +: 2]) else $error("even channel clock source leaks");
        split_ctl_a: assert property (!q.module_control[pwmcab_pkg::CTL_JOIN_PAIR_ZERO_ONE + p] // [RL1]
            |=> eff_enable[2*p +: 2] == $past(q.channel_enable[2*p +: 2])
            && eff_centre[2*p +: 2] == $past(q.centre_align[2*p +: 2])) else $error("split pair controls wrong");
    end

    // per-channel source checks, selects take one edge to reach the outputs
    for (genvar c = 0; c < NCH; c++) begin : g_chan_chk
        localparam logic FAM_FLIP = ((c % 4) >= 2);
        scaled_src_a: assert property (!q.joined[c/2] // [RL11] [RL12]
            |=> chan_src[2*c] == $past(q.scaled_select_register[c])) else $error("scaled select not applied");
        family_src_a: assert property (!q.joined[c/2] // [RL9] [RL10]
            |=> chan_src[2*c+1] == ($past(q.clock_family_select[c]) ^ FAM_FLIP)) else $error("family select wrong");
        clock_a_route_a: assert property (q.prescaler_run && !q.joined[c/2] // [RL11] [RL12]
            && !q.scaled_select_register[c] && q.clock_family_select[c] == FAM_FLIP
            |=> chan_tick[c] == $past(tick_a)) else $error("clock A tick not routed");
        clock_sb_route_a: assert property (q.prescaler_run && !q.joined[c/2] // [RL11] [RL12]
            && q.scaled_select_register[c] && q.clock_family_select[c] != FAM_FLIP
            |=> chan_tick[c] == $past(tick_sb)) else $error("clock SB tick not routed");
    end

    // apb response and register write checks
    ctl_write_a: assert property (q.st == pwmcab_pkg::PWMCAB_ST_RESP && psel && penable && pwrite // [RL3] [RL13]
        && acc_idx == pwmcab_pkg::IDX_MODULE_CONTROL && paddr[1:0] == 2'b00
        |=> q.module_control == ($past(pwdata[7:0]) & ctl_wmask)) else $error("control write lost");

    free_run_a: assert property (!(mcu_wait && q.module_control[pwmcab_pkg::CTL_HALT_IN_WAIT]) // [RL6] [RL7]
        && !(mcu_freeze && q.module_control[pwmcab_pkg::CTL_HALT_IN_FREEZE])
        |=> prescaler_run) else $error("prescaler stopped without halt request");

    freeze_access_a: assert property (mcu_freeze && psel && penable && q.st == pwmcab_pkg::PWMCAB_ST_IDLE // [RL8]
        |=> pready) else $error("register access blocked in freeze");

    resp_pulse_a: assert property (pready |=> !pready) else $error("ready held past one cycle");

    err_data_a: assert property (pslverr |-> pready && prdata == pwmcab_pkg::RDATA_RESET)
        else $error("error response carries data");

    misalign_err_a: assert property (q.st == pwmcab_pkg::PWMCAB_ST_IDLE && psel && penable && paddr[1:0] != 2'b00
        |=> pslverr) else $error("misaligned access not refused");

    err_no_write_a: assert property (pslverr && psel && penable && pwrite
        |=> $stable(q.module_control) && $stable(q.clock_family_select)) else $error("refused write stored");

    read_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits not zero");

endmodule

`default_nettype wire

// >>> bench/pwmcab_test.sv
`timescale 1ns/1ps
`default_nettype none

module pwmcab_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [pwmcab_pkg::APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mcu_wait = 1'b0;
    logic mcu_freeze = 1'b0;
    logic tick_a = 1'b0;
    logic tick_b = 1'b0;
    logic tick_sa = 1'b0;
    logic tick_sb = 1'b0;
    logic [7:0] chan_wave = '0;
    logic [3:0] wave16 = '0;
    logic [7:0] chan_tick;
    logic [15:0] chan_src;
    logic [3:0] pair_joined;
    logic prescaler_run;
    logic [7:0] eff_enable;
    logic [7:0] eff_polarity;
    logic [7:0] eff_centre;
    logic [7:0] pwm_output_port;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    pwmcab_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mcu_wait(mcu_wait), .mcu_freeze(mcu_freeze), .tick_a(tick_a), .tick_b(tick_b),
        .tick_sa(tick_sa), .tick_sb(tick_sb), .chan_wave(chan_wave), .wave16(wave16),
        .chan_tick(chan_tick), .chan_src(chan_src), .pair_joined(pair_joined),
        .prescaler_run(prescaler_run), .eff_enable(eff_enable), .eff_polarity(eff_polarity),
        .eff_centre(eff_centre), .pwm_output_port(pwm_output_port));

    always #10 pclk = ~pclk;

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
        output logic [31:0] rdv, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1, "no pready");
        chk(n, 32'd2, "one wait state");
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, {idx, 2'b00}, d, rd, er);
        chk({31'h0, er}, 32'h0, "write error");
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, {idx, 2'b00}, 32'h0, rd, er);
        chk({31'h0, er}, 32'h0, "read error");
        chk(rd, exp, what);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic t_regs;
        rdchk(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h0, "ctl reset");
        rdchk(pwmcab_pkg::IDX_CLOCK_FAMILY, 32'h0, "family reset");
        rdchk(pwmcab_pkg::IDX_STATUS, 32'h4, "status reset");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'hffff_ffff);
        rdchk(pwmcab_pkg::IDX_MODULE_CONTROL, 32'hfc, "ctl readback");
        wr(pwmcab_pkg::IDX_CLOCK_FAMILY, 32'hffff_ff5a);
        rdchk(pwmcab_pkg::IDX_CLOCK_FAMILY, 32'h5a, "family readback");
        for (int p = 0; p < 4; p++) begin
            wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h10 << p);
            idle(2);
            chk({28'h0, pair_joined}, 32'h1 << p, "join bit position");
        end
        apb(1'b0, 8'hfc, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h15, 32'hff, rd, er);
        chk({31'h0, er}, 32'h1, "misaligned err");
        rdchk(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h80, "ctl kept");
        $display("test regs done");
    endtask

    task automatic t_source;
        logic [7:0] sv[3] = '{8'h00, 8'hff, 8'h0f};
        logic [7:0] fv[3] = '{8'h00, 8'hff, 8'h33};
        logic [15:0] es;
        logic [7:0] et;
        logic [1:0] c;
        logic [7:0] fam_flip = 8'hcc;
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                wr(pwmcab_pkg::IDX_SCALED_SELECT, {24'h0, sv[i]});
                wr(pwmcab_pkg::IDX_CLOCK_FAMILY, {24'h0, fv[j]});
                for (int k = 0; k < 4; k++) begin
                    @(posedge pclk);
                    {tick_a, tick_sa, tick_b, tick_sb} <= 4'b1000 >> k;
                    idle(3);
                    for (int ch = 0; ch < 8; ch++) begin
                        c = {fv[j][ch] ^ fam_flip[ch], sv[i][ch]};
                        es[2*ch +: 2] = c;
                        et[ch] = (c == 2'(k));
                    end
                    chk({16'h0, chan_src}, {16'h0, es}, "chan_src");
                    chk({24'h0, chan_tick}, {24'h0, et}, "chan_tick");
                end
            end
        end
        $display("test source done");
    endtask

    task automatic t_gate;
        wr(pwmcab_pkg::IDX_SCALED_SELECT, 32'h0);
        wr(pwmcab_pkg::IDX_CLOCK_FAMILY, 32'h0);
        @(posedge pclk);
        {tick_a, tick_sa, tick_b, tick_sb} <= 4'b1000;
        mcu_wait <= 1'b1;
        idle(3);
        chk({31'h0, prescaler_run}, 32'h1, "wait run with bit clear");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h08);
        idle(3);
        chk({31'h0, prescaler_run}, 32'h0, "wait gated");
        chk({24'h0, chan_tick}, 32'h0, "ticks held in wait");
        rdchk(pwmcab_pkg::IDX_STATUS, 32'h1, "status wait");
        @(posedge pclk);
        mcu_wait <= 1'b0;
        mcu_freeze <= 1'b1;
        idle(3);
        chk({31'h0, prescaler_run}, 32'h1, "freeze with wait bit");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h04);
        idle(3);
        chk({31'h0, prescaler_run}, 32'h0, "freeze gated");
        chk({24'h0, chan_tick}, 32'h0, "ticks held in freeze");
        rdchk(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h04, "regs in freeze");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h0);
        idle(3);
        chk({31'h0, prescaler_run}, 32'h1, "resume on bit clear");
        chk({24'h0, chan_tick}, 32'h33, "ticks resume");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h04);
        @(posedge pclk);
        mcu_freeze <= 1'b0;
        idle(3);
        chk({31'h0, prescaler_run}, 32'h1, "resume on exit");
        $display("test gate done");
    endtask

    task automatic t_join;
        wr(pwmcab_pkg::IDX_CHANNEL_ENABLE, 32'haa);
        wr(pwmcab_pkg::IDX_OUTPUT_POLARITY, 32'h55);
        wr(pwmcab_pkg::IDX_CENTRE_ALIGN, 32'haa);
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h0);
        @(posedge pclk);
        chan_wave <= 8'ha5;
        wave16 <= 4'b1010;
        idle(3);
        chk({24'h0, eff_enable}, 32'haa, "separate enable");
        chk({24'h0, pwm_output_port}, 32'ha5, "separate pins");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'hf0);
        idle(3);
        chk({28'h0, pair_joined}, 32'hf, "all joined");
        chk({24'h0, eff_enable}, 32'hff, "odd enable");
        chk({24'h0, eff_polarity}, 32'h00, "odd polarity");
        chk({24'h0, eff_centre}, 32'hff, "odd centre");
        chk({24'h0, pwm_output_port}, 32'h88, "odd pins");
        wr(pwmcab_pkg::IDX_MODULE_CONTROL, 32'h10);
        idle(3);
        chk({24'h0, pwm_output_port}, 32'ha4, "pair zero joined");
        $display("test join done");
    endtask

    initial begin
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, prescaler_run}, 32'h1, "run after reset");
        t_regs();
        t_source();
        t_gate();
        t_join();
        results();
    end
endmodule

`default_nettype wire
